//--- i2cm_params.svh
// timing and field constants for the i2c master
`ifndef I2CM_PARAMS_SVH
`define I2CM_PARAMS_SVH

`define I2CM_LINK_PERIOD_NS 48
`define I2CM_HALF_STD_NS 5000
`define I2CM_HALF_FAST_NS 1250
`define I2CM_HALF_FPLUS_NS 500
`define I2CM_HALF_HS_NS 147
`define I2CM_CYC(ns) (((ns) + `I2CM_LINK_PERIOD_NS - 1) / `I2CM_LINK_PERIOD_NS)
`define I2CM_HALF_STD_CYC `I2CM_CYC(`I2CM_HALF_STD_NS)
`define I2CM_HALF_FAST_CYC `I2CM_CYC(`I2CM_HALF_FAST_NS)
`define I2CM_HALF_FPLUS_CYC `I2CM_CYC(`I2CM_HALF_FPLUS_NS)
`define I2CM_HALF_HS_CYC `I2CM_CYC(`I2CM_HALF_HS_NS)
`define I2CM_CODE_GROUP 5'h01
`define I2CM_MASTER_CODE_DEF 3'h1
`define I2CM_BIT_LAST 4'h8

`endif

//--- i2cm_pkg.sv
// types shared by the i2c master files
package i2cm_pkg;

  typedef enum logic [2:0] {
    OP_START, OP_WRITE, OP_READ, OP_STOP, OP_HSCODE
  } i2cm_op_type;

  typedef enum logic [1:0] {
    SPD_STD, SPD_FAST, SPD_FPLUS
  } i2cm_speed_type;

  typedef struct packed {
    i2cm_op_type op;
    i2cm_speed_type speed;
    logic isAddress;
    logic ackSend;
    logic [7:0] data;
  } i2cm_cmd_type;

  typedef struct packed {
    logic [7:0] rxData;
    logic ackSeen;
    logic addrNack;
    logic arbLost;
    logic refused;
  } i2cm_result_type;

  typedef enum logic [3:0] {
    L_IDLE, L_WAITFREE, L_RS1, L_ST1, L_ST2, L_ST3,
    L_BLO, L_BHI, L_SP1, L_SP2, L_SP3, L_FIN
  } i2cm_link_state_type;

endpackage

//--- i2cm_sync.sv
// three-stage synchroniser, output follows once stages two and three agree
`timescale 1ns/1ns
module i2cm_sync #(
  parameter logic INIT = 1'b0
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic d,
  output logic q
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      q <= INIT;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        q <= s2_q;
      end
    end
  end

endmodule

//--- i2c_master_bus_controller.sv
// i2c master: command handshake on clock, bus engine on linkClock
`timescale 1ns/1ns
`include "i2cm_params.svh"
module i2c_master_bus_controller #(
  parameter logic [2:0] MASTER_CODE = `I2CM_MASTER_CODE_DEF
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic linkClock,
  input wire logic cmdValid,
  input wire i2cm_pkg::i2cm_cmd_type cmd,
  output logic cmdReady,
  output logic done,
  output i2cm_pkg::i2cm_result_type result,
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe_n,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe_n
);

  // clock domain
  i2cm_pkg::i2cm_cmd_type hold_q;
  logic reqTgl_q;
  logic ackTglSeen_q;
  logic ackTglSync;

  // link domain
  logic linkRst_n;
  logic sclS;
  logic sdaS;
  logic sdaPrev_q;
  logic busBusy_q;
  logic reqTglSync;
  logic reqTglSeen_q;
  logic ackTgl_q;
  i2cm_pkg::i2cm_link_state_type state_q;
  i2cm_pkg::i2cm_cmd_type lcmd_q;
  i2cm_pkg::i2cm_result_type lres_q;
  logic [7:0] tmr_q;
  logic [7:0] halfCyc;
  logic [8:0] shift_q;
  logic [8:0] rx_q;
  logic [3:0] bitCnt_q;
  logic sclLow_q;
  logic sdaLow_q;
  logic ownBus_q;
  logic hsActive_q;
  logic hsPend_q;
  logic addrNack_q;
  logic startSeen;
  logic stopSeen;
  logic arbCheck;

  // ---------------- command side ----------------

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      hold_q <= '0;
      reqTgl_q <= 1'b0;
      ackTglSeen_q <= 1'b0;
      cmdReady <= 1'b1;
      done <= 1'b0;
      result <= '0;
    end else begin
      done <= 1'b0;
      if (cmdValid && cmdReady) begin
        hold_q <= cmd;
        reqTgl_q <= ~reqTgl_q;
        cmdReady <= 1'b0;
      end else if (ackTglSync != ackTglSeen_q) begin
        ackTglSeen_q <= ackTglSync;
        result <= lres_q;
        done <= 1'b1;
        cmdReady <= 1'b1;
      end
    end
  end

  i2cm_sync #(.INIT(1'b0)) uAckSync (
    .clock(clock),
    .reset_n(reset_n),
    .d(ackTgl_q),
    .q(ackTglSync)
  );

  // ---------------- link side ----------------

  // reset crosses into the link domain as a level
  i2cm_sync #(.INIT(1'b0)) uRstSync (
    .clock(linkClock),
    .reset_n(1'b1),
    .d(reset_n),
    .q(linkRst_n)
  );

  i2cm_sync #(.INIT(1'b0)) uReqSync (
    .clock(linkClock),
    .reset_n(linkRst_n),
    .d(reqTgl_q),
    .q(reqTglSync)
  );

  i2cm_sync #(.INIT(1'b1)) uSclSync (
    .clock(linkClock),
    .reset_n(linkRst_n),
    .d(sclIn),
    .q(sclS)
  );

  i2cm_sync #(.INIT(1'b1)) uSdaSync (
    .clock(linkClock),
    .reset_n(linkRst_n),
    .d(sdaIn),
    .q(sdaS)
  );

  // bus monitor: start and stop by any master
  assign startSeen = sclS & sdaPrev_q & ~sdaS;
  assign stopSeen = sclS & ~sdaPrev_q & sdaS;

  always_ff @(posedge linkClock) begin
    if (!linkRst_n) begin
      sdaPrev_q <= 1'b1;
      busBusy_q <= 1'b0;
    end else begin
      sdaPrev_q <= sdaS;
      if (startSeen) begin
        busBusy_q <= 1'b1;
      end else if (stopSeen) begin
        busBusy_q <= 1'b0;
      end
    end
  end

  // half bit time; code byte at the rate set by the command's speed field
  always_comb begin
    halfCyc = 8'(`I2CM_HALF_STD_CYC - 1);
    if (hsActive_q) begin
      halfCyc = 8'(`I2CM_HALF_HS_CYC - 1);
    end else if (lcmd_q.speed == i2cm_pkg::SPD_FAST) begin
      halfCyc = 8'(`I2CM_HALF_FAST_CYC - 1);
    end else if (lcmd_q.speed == i2cm_pkg::SPD_FPLUS) begin
      halfCyc = 8'(`I2CM_HALF_FPLUS_CYC - 1);
    end
  end

  // outside hs mode, write data bits and the read acknowledge bit where this master sends a one are checked against the line
  always_comb begin
    if (lcmd_q.op == i2cm_pkg::OP_READ) begin
      arbCheck = (bitCnt_q == 4'h0);
    end else begin
      arbCheck = (bitCnt_q != 4'h0);
    end
    arbCheck = arbCheck & shift_q[8] & ~hsActive_q;
  end

  always_ff @(posedge linkClock) begin
    if (!linkRst_n) begin
      state_q <= i2cm_pkg::L_IDLE;
      lcmd_q <= '0;
      lres_q <= '0;
      tmr_q <= 8'h00;
      shift_q <= 9'h1ff;
      rx_q <= 9'h000;
      bitCnt_q <= 4'h0;
      sclLow_q <= 1'b0;
      sdaLow_q <= 1'b0;
      ownBus_q <= 1'b0;
      hsActive_q <= 1'b0;
      hsPend_q <= 1'b0;
      addrNack_q <= 1'b0;
      reqTglSeen_q <= 1'b0;
      ackTgl_q <= 1'b0;
    end else begin
      if (tmr_q != 8'h00) begin
        tmr_q <= tmr_q - 8'h01;
      end
      case (state_q)
        i2cm_pkg::L_IDLE: begin
          if (reqTglSync != reqTglSeen_q) begin
            reqTglSeen_q <= reqTglSync;
            lcmd_q <= hold_q;
            lres_q <= '0;
            tmr_q <= halfCyc;
            case (hold_q.op)
              i2cm_pkg::OP_START, i2cm_pkg::OP_HSCODE: begin
                hsPend_q <= (hold_q.op == i2cm_pkg::OP_HSCODE);
                addrNack_q <= 1'b0;
                state_q <= ownBus_q ? i2cm_pkg::L_RS1 : i2cm_pkg::L_WAITFREE;
              end
              i2cm_pkg::OP_WRITE, i2cm_pkg::OP_READ: begin
                if (!ownBus_q || (addrNack_q && !hold_q.isAddress)) begin
                  lres_q.refused <= 1'b1;
                  lres_q.addrNack <= addrNack_q;
                  state_q <= i2cm_pkg::L_FIN;
                end else begin
                  bitCnt_q <= `I2CM_BIT_LAST;
                  if (hold_q.op == i2cm_pkg::OP_WRITE) begin
                    shift_q <= {hold_q.data, 1'b1};
                  end else begin
                    shift_q <= {8'hff, ~hold_q.ackSend};
                  end
                  state_q <= i2cm_pkg::L_BLO;
                end
              end
              i2cm_pkg::OP_STOP: begin
                state_q <= ownBus_q ? i2cm_pkg::L_SP1 : i2cm_pkg::L_FIN;
              end
              default: begin
                lres_q.refused <= 1'b1;
                state_q <= i2cm_pkg::L_FIN;
              end
            endcase
          end
        end
        i2cm_pkg::L_WAITFREE: begin
          tmr_q <= halfCyc;
          if (!busBusy_q) begin
            state_q <= i2cm_pkg::L_ST1;
          end
        end
        i2cm_pkg::L_RS1: begin
          sdaLow_q <= 1'b0;
          if (tmr_q == 8'h00) begin
            tmr_q <= halfCyc;
            state_q <= i2cm_pkg::L_ST1;
          end
        end
        i2cm_pkg::L_ST1: begin
          sclLow_q <= 1'b0;
          if (!sclS) begin
            tmr_q <= halfCyc;
          end else if (!sdaS && !hsActive_q) begin
            lres_q.arbLost <= 1'b1;
            ownBus_q <= 1'b0;
            state_q <= i2cm_pkg::L_FIN;
          end else if (tmr_q == 8'h00) begin
            sdaLow_q <= 1'b1;
            ownBus_q <= 1'b1;
            tmr_q <= halfCyc;
            state_q <= i2cm_pkg::L_ST2;
          end
        end
        i2cm_pkg::L_ST2: begin
          if (tmr_q == 8'h00) begin
            sclLow_q <= 1'b1;
            tmr_q <= halfCyc;
            state_q <= i2cm_pkg::L_ST3;
          end
        end
        i2cm_pkg::L_ST3: begin
          if (tmr_q == 8'h00) begin
            tmr_q <= halfCyc;
            if (hsPend_q && !hsActive_q) begin
              bitCnt_q <= `I2CM_BIT_LAST;
              shift_q <= {`I2CM_CODE_GROUP, MASTER_CODE, 1'b1};
              state_q <= i2cm_pkg::L_BLO;
            end else begin
              hsPend_q <= 1'b0;
              state_q <= i2cm_pkg::L_FIN;
            end
          end
        end
        i2cm_pkg::L_BLO: begin
          sclLow_q <= 1'b1;
          // data moves a cycle after the clock is already low
          sdaLow_q <= ~shift_q[8];
          if (tmr_q == 8'h00) begin
            tmr_q <= halfCyc;
            state_q <= i2cm_pkg::L_BHI;
          end
        end
        i2cm_pkg::L_BHI: begin
          sclLow_q <= 1'b0;
          if (!sclS) begin
            tmr_q <= halfCyc;
          end else if (tmr_q == 8'h00) begin
            rx_q <= {rx_q[7:0], sdaS};
            shift_q <= {shift_q[7:0], 1'b1};
            tmr_q <= halfCyc;
            if (arbCheck && !sdaS) begin
              lres_q.arbLost <= 1'b1;
              ownBus_q <= 1'b0;
              hsPend_q <= 1'b0;
              sdaLow_q <= 1'b0;
              state_q <= i2cm_pkg::L_FIN;
            end else if (bitCnt_q != 4'h0) begin
              bitCnt_q <= bitCnt_q - 4'h1;
              sclLow_q <= 1'b1;
              state_q <= i2cm_pkg::L_BLO;
            end else if (hsPend_q && !hsActive_q) begin
              // code slot is never acknowledged; not an error
              lres_q.ackSeen <= ~sdaS;
              hsActive_q <= 1'b1;
              sclLow_q <= 1'b1;
              state_q <= i2cm_pkg::L_RS1;
            end else begin
              lres_q.ackSeen <= ~sdaS;
              lres_q.rxData <= rx_q[7:0];
              if (lcmd_q.op == i2cm_pkg::OP_WRITE && lcmd_q.isAddress
                  && sdaS) begin
                addrNack_q <= 1'b1;
                lres_q.addrNack <= 1'b1;
              end
              sclLow_q <= 1'b1;
              state_q <= i2cm_pkg::L_FIN;
            end
          end
        end
        i2cm_pkg::L_SP1: begin
          sclLow_q <= 1'b1;
          sdaLow_q <= 1'b1;
          if (tmr_q == 8'h00) begin
            tmr_q <= halfCyc;
            state_q <= i2cm_pkg::L_SP2;
          end
        end
        i2cm_pkg::L_SP2: begin
          sclLow_q <= 1'b0;
          if (!sclS) begin
            tmr_q <= halfCyc;
          end else if (tmr_q == 8'h00) begin
            sdaLow_q <= 1'b0;
            tmr_q <= halfCyc;
            state_q <= i2cm_pkg::L_SP3;
          end
        end
        i2cm_pkg::L_SP3: begin
          if (tmr_q == 8'h00) begin
            ownBus_q <= 1'b0;
            hsActive_q <= 1'b0;
            addrNack_q <= 1'b0;
            state_q <= i2cm_pkg::L_FIN;
          end
        end
        i2cm_pkg::L_FIN: begin
          if (!ownBus_q) begin
            sclLow_q <= 1'b0;
            sdaLow_q <= 1'b0;
            hsActive_q <= 1'b0;
          end
          ackTgl_q <= ~ackTgl_q;
          state_q <= i2cm_pkg::L_IDLE;
        end
        default: begin
          state_q <= i2cm_pkg::L_IDLE;
        end
      endcase
    end
  end

  // pins: open drain, output value fixed low
  always_ff @(posedge linkClock) begin
    if (!linkRst_n) begin
      sclOut <= 1'b0;
      sdaOut <= 1'b0;
      sclOe_n <= 1'b1;
      sdaOe_n <= 1'b1;
    end else begin
      sclOut <= 1'b0;
      sdaOut <= 1'b0;
      sclOe_n <= ~sclLow_q;
      sdaOe_n <= ~sdaLow_q;
    end
  end

endmodule

//--- i2cm_props.sv
// assertions on the i2c master top-level ports
`timescale 1ns/1ns
module i2cm_props (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic linkClock,
  input wire logic cmdValid,
  input wire i2cm_pkg::i2cm_cmd_type cmd,
  input wire logic cmdReady,
  input wire logic done,
  input wire i2cm_pkg::i2cm_result_type result,
  input wire logic sclIn,
  input wire logic sclOut,
  input wire logic sclOe_n,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe_n
);
  pad_out_low_a: assert property (
    @(posedge clock) disable iff (!reset_n) !sclOut && !sdaOut)
    else $error("pad output driven high");
  take_drops_ready_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    cmdValid && cmdReady |=> !cmdReady)
    else $error("ready stays high after take");
  ready_fall_take_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    $fell(cmdReady) |-> $past(cmdValid))
    else $error("ready fell without a request");
  done_single_a: assert property (
    @(posedge clock) disable iff (!reset_n) done |=> !done)
    else $error("done longer than one cycle");
  done_ready_a: assert property (
    @(posedge clock) disable iff (!reset_n) done |-> cmdReady)
    else $error("done without ready");
  reset_idle_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    $rose(reset_n) |-> sclOe_n && sdaOe_n && cmdReady && !done)
    else $error("not idle after reset");
  sda_edge_sclhigh_a: assert property (
    @(posedge linkClock) disable iff (!reset_n)
    $changed(sdaOe_n) && sclOe_n && $past(sclOe_n) |-> sclIn)
    else $error("data moved with clock released but low");
  stretch_wait_a: assert property (
    @(posedge linkClock) disable iff (!reset_n)
    sclOe_n && !sclIn && $past(sclOe_n) |=> $stable(sdaOe_n) && sclOe_n)
    else $error("moved on while clock held low");
endmodule

//--- i2cm_slave_model.sv
// behavioural i2c slave on the open-drain wires
`timescale 1ns/1ns
module i2cm_slave_model #(
  parameter logic [3:0] CATEGORY = 4'ha,
  parameter logic [2:0] PINS = 3'h5
) (
  input wire logic scl,
  input wire logic sda,
  input wire logic [7:0] txByte,
  input wire logic stretch,
  output logic sdaLow,
  output logic sclLow,
  output logic [7:0] rxByte
);
  int bitCnt;
  logic [7:0] sh;
  logic active, first, rdMode, ackBit;
  initial begin
    {sdaLow, sclLow, active, first, rdMode, ackBit} = '0;
    bitCnt = 0;
    sh = '0;
    rxByte = '0;
  end
  always @(negedge sda) begin
    if (scl) begin
      active = 1'b1;
      first = 1'b1;
      rdMode = 1'b0;
      bitCnt = 0;
    end
  end
  always @(posedge sda) begin
    if (scl) begin
      active = 1'b0;
      sdaLow = 1'b0;
    end
  end
  always @(posedge scl) begin
    if (active) begin
      if (bitCnt < 8)
        sh = {sh[6:0], sda};
      else
        ackBit = sda;
      bitCnt = bitCnt + 1;
    end
  end
  // only drives or releases, never high
  always @(negedge scl) begin
    if (active) begin
      if (bitCnt == 8) begin
        rxByte = sh;
        if (first) begin
          rdMode = sh[0];
          active = (sh[7:1] == {CATEGORY, PINS});
        end
        sdaLow = active && (first || !rdMode);
      end else if (bitCnt == 9) begin
        bitCnt = 0;
        first = 1'b0;
        sdaLow = rdMode && !ackBit && !txByte[7];
        if (stretch) begin
          sclLow <= 1'b1;
          sclLow <= #2000 1'b0;
        end
      end else if (rdMode) begin
        sdaLow = !txByte[7 - bitCnt];
      end
    end
  end
endmodule

//--- tb.sv
// self-checking bench for the i2c master
`timescale 1ns/1ns
module tb;
  localparam logic [6:0] ADDR = 7'h55;
  logic clock, reset_n, linkClock, cmdValid, cmdReady, done;
  i2cm_pkg::i2cm_cmd_type cmd;
  i2cm_pkg::i2cm_result_type result, res;
  i2cm_pkg::i2cm_speed_type spd;
  logic sclOut, sclOe_n, sdaOut, sdaOe_n, sclW, sdaW;
  logic slvSda, slvScl, otherSda, stretch, got;
  logic [7:0] slvRx;
  int nErrors, totalChecks, cycles;
  assign sclW = sclOe_n & !slvScl;
  assign sdaW = sdaOe_n & !slvSda & !otherSda;
  i2c_master_bus_controller #(.MASTER_CODE(3'h6)) dut (.clock, .reset_n,
    .linkClock, .cmdValid, .cmd, .cmdReady, .done, .result, .sclIn(sclW),
    .sclOut, .sclOe_n, .sdaIn(sdaW), .sdaOut, .sdaOe_n);
  i2cm_slave_model slv (.scl(sclW), .sda(sdaW), .txByte(8'h5a),
    .stretch, .sdaLow(slvSda), .sclLow(slvScl), .rxByte(slvRx));
  initial begin
    clock = 1'b0;
    forever #25 clock = !clock;
  end
  initial begin
    linkClock = 1'b0;
    #7;
    forever #24 linkClock = !linkClock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      nErrors++;
      printVerdict;
    end
  end
  task automatic printVerdict;
    if (nErrors == 0 && totalChecks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      nErrors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic send(input i2cm_pkg::i2cm_op_type op, input logic [7:0] d,
    input logic isA, input logic ack);
    @(posedge clock);
    cmdValid <= 1'b1;
    cmd <= '{op: op, speed: spd, isAddress: isA, ackSend: ack, data: d};
    @(posedge clock);
    cmdValid <= 1'b0;
  endtask
  task automatic waitDone(input int limit);
    int w;
    w = 0;
    got = 1'b0;
    while (w < limit && !got) begin
      @(negedge clock);
      w++;
      got = (done === 1'b1);
    end
    res = result;
  endtask
  task automatic issue(input i2cm_pkg::i2cm_op_type op, input logic [7:0] d,
    input logic isA, input logic ack);
    send(op, d, isA, ack);
    waitDone(6000);
    check(got, 1'b1);
  endtask
  task automatic write_txn(input i2cm_pkg::i2cm_speed_type s);
    spd = s;
    issue(i2cm_pkg::OP_START, 8'h00, 1'b0, 1'b0);
    issue(i2cm_pkg::OP_WRITE, {ADDR, 1'b0}, 1'b1, 1'b0);
    check(res.ackSeen, 1'b1);
    issue(i2cm_pkg::OP_WRITE, 8'h96, 1'b0, 1'b0);
    check(slvRx, 8'h96);
    check(res.ackSeen, 1'b1);
    issue(i2cm_pkg::OP_STOP, 8'h00, 1'b0, 1'b0);
    check({sclW, sdaW}, 2'h3);
  endtask
  task automatic read_txn;
    spd = i2cm_pkg::SPD_FAST;
    stretch = 1'b1;
    issue(i2cm_pkg::OP_START, 8'h00, 1'b0, 1'b0);
    issue(i2cm_pkg::OP_WRITE, {ADDR, 1'b1}, 1'b1, 1'b0);
    check(res.ackSeen, 1'b1);
    issue(i2cm_pkg::OP_READ, 8'h00, 1'b0, 1'b0);
    check(res.rxData, 8'h5a);
    check(res.ackSeen, 1'b0);
    issue(i2cm_pkg::OP_STOP, 8'h00, 1'b0, 1'b0);
    stretch = 1'b0;
  endtask
  task automatic nack_txn;
    issue(i2cm_pkg::OP_START, 8'h00, 1'b0, 1'b0);
    issue(i2cm_pkg::OP_WRITE, 8'h24, 1'b1, 1'b0);
    check({res.addrNack, res.ackSeen}, 2'h2);
    issue(i2cm_pkg::OP_WRITE, 8'h3c, 1'b0, 1'b0);
    check(res.refused, 1'b1);
    issue(i2cm_pkg::OP_STOP, 8'h00, 1'b0, 1'b0);
  endtask
  task automatic arb_txn;
    issue(i2cm_pkg::OP_START, 8'h00, 1'b0, 1'b0);
    issue(i2cm_pkg::OP_WRITE, {ADDR, 1'b0}, 1'b1, 1'b0);
    otherSda <= 1'b1;
    issue(i2cm_pkg::OP_WRITE, 8'hff, 1'b0, 1'b0);
    check(res.arbLost, 1'b1);
    send(i2cm_pkg::OP_START, 8'h00, 1'b0, 1'b0);
    waitDone(3000);
    check(got, 1'b0);
    otherSda <= 1'b0;
    waitDone(6000);
    check({got, res.arbLost}, 2'h2);
    issue(i2cm_pkg::OP_STOP, 8'h00, 1'b0, 1'b0);
  endtask
  task automatic hs_txn;
    issue(i2cm_pkg::OP_HSCODE, 8'h00, 1'b0, 1'b0);
    check({res.arbLost, res.addrNack}, 2'h0);
    check(res.ackSeen, 1'b0);
    check(slvRx, {5'h01, 3'h6});
    issue(i2cm_pkg::OP_WRITE, {ADDR, 1'b0}, 1'b1, 1'b0);
    check(res.ackSeen, 1'b1);
    // a low data line after the code must not count as a loss
    otherSda <= 1'b1;
    issue(i2cm_pkg::OP_WRITE, 8'hff, 1'b0, 1'b0);
    check(res.arbLost, 1'b0);
    otherSda <= 1'b0;
    issue(i2cm_pkg::OP_STOP, 8'h00, 1'b0, 1'b0);
  endtask
  initial begin
    {reset_n, cmdValid, otherSda, stretch} = '0;
    cmd = '0;
    spd = i2cm_pkg::SPD_STD;
    {nErrors, totalChecks, cycles} = '0;
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    repeat (12) @(posedge clock);
    write_txn(i2cm_pkg::SPD_STD);
    write_txn(i2cm_pkg::SPD_FAST);
    write_txn(i2cm_pkg::SPD_FPLUS);
    read_txn;
    nack_txn;
    arb_txn;
    hs_txn;
    printVerdict;
  end
endmodule
bind i2c_master_bus_controller i2cm_props chk (.clock, .reset_n,
  .linkClock, .cmdValid, .cmd, .cmdReady, .done, .result, .sclIn,
  .sclOut, .sclOe_n, .sdaIn, .sdaOut, .sdaOe_n);
